// ==== logic/seq_pkg.sv ====
package seq_pkg;

    // ----------------------------------------------------------------
    // multiplexer selects
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MUX_TEMP = 3'h0,
        MUX_OFFSET = 3'h1,
        MUX_BRIDGE = 3'h2,
        MUX_CMODE = 3'h3,
        MUX_SHORT_POS = 3'h4,
        MUX_SHORT_NEG = 3'h5
    } mux_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CONV = 2'h1,
        ST_HAND = 2'h2
    } seq_state_t;

    // ----------------------------------------------------------------
    // configuration and timing constants
    // ----------------------------------------------------------------
    localparam logic [4:0] BRIDGE_CNT_MIN = 5'h01;
    localparam logic [4:0] BRIDGE_CNT_RST = 5'h01;
    localparam logic [2:0] START_CONVS = 3'h5;
    localparam logic [1:0] RES_13 = 2'h0;
    localparam logic [1:0] RES_14 = 2'h1;
    localparam logic [1:0] RES_15 = 2'h2;
    localparam logic [1:0] RES_16 = 2'h3;
    localparam int RES_BASE = 13;
    localparam int SECOND_ORDER_ADD = 3;
    localparam int SEGMENT_BITS = 14;
    localparam int OSC_DIV = 2;
    localparam logic [4:0] CHK_STEPS = 5'h03;

    // ----------------------------------------------------------------
    // grouped signals
    // ----------------------------------------------------------------
    typedef struct packed {
        logic order_bridge_first;
        logic [4:0] bridge_count;
        logic [1:0] resolution;
        logic second_order;
        logic [1:0] range_shift;
        logic reference_select;
        logic [1:0] temp_source;
    } app_config_t;

    typedef struct packed {
        logic start;
        mux_sel_t mux;
        logic [1:0] resolution;
        logic second_order;
        logic [1:0] range_shift;
        logic reference_select;
        logic [1:0] temp_source;
    } conv_cmd_t;

endpackage

// ==== logic/conv_timer.sv ====
module conv_timer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [1:0] resolution_i,
    input wire logic second_order_i,
    output logic done_o
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [17:0] cnt;
    } tmr_t;

    tmr_t st_ff;
    tmr_t nxt_st;
    logic [4:0] res_bits;
    logic [4:0] exp_bits;

    // ----------------------------------------------------------------
    // conversion length in oscillator periods
    // ----------------------------------------------------------------
    always_comb begin
        res_bits = 5'(seq_pkg::RES_BASE) + {3'h0, resolution_i};
        if (second_order_i) begin
            exp_bits = 5'((res_bits + 5'(seq_pkg::SECOND_ORDER_ADD)) >> 1);
        end else begin
            exp_bits = res_bits;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start_i && !st_ff.busy) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 18'(seq_pkg::OSC_DIV) << exp_bits;
        end else if (st_ff.busy) begin
            if (st_ff.cnt <= 18'h00001) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
                nxt_st.cnt = 18'h00000;
            end else begin
                nxt_st.cnt = st_ff.cnt - 18'h00001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
endmodule

// ==== logic/bridge_measurement_sequencer.sv ====
module bridge_measurement_sequencer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire seq_pkg::app_config_t cfg_i,
    input wire logic [15:0] adc_count_i,
    input wire logic ctrl_ack_i,
    output seq_pkg::conv_cmd_t cmd_o,
    output logic [13:0] result_o,
    output logic result_valid_o,
    output logic start_done_o,
    output logic cycle_end_o
);
    typedef struct packed {
        seq_pkg::seq_state_t state;
        seq_pkg::conv_cmd_t cmd;
        logic [2:0] phase;
        logic [4:0] bridge_left;
        logic [4:0] bridge_tot;
        logic order_first;
        logic [2:0] start_cnt;
        logic start_done;
        logic [13:0] result;
        logic result_valid;
        logic cycle_end;
    } seq_st_t;

    seq_st_t st_ff;
    seq_st_t nxt_st;
    logic conv_done;
    logic [4:0] bridge_n;
    logic [2:0] last_phase;

    // ----------------------------------------------------------------
    // conversion timer
    // ----------------------------------------------------------------
    conv_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(st_ff.cmd.start),
        .resolution_i(st_ff.cmd.resolution),
        .second_order_i(st_ff.cmd.second_order),
        .done_o(conv_done)
    );

    // ----------------------------------------------------------------
    // phase to mux mapping
    // ----------------------------------------------------------------
    function automatic seq_pkg::mux_sel_t phase_mux(
        input logic [2:0] ph,
        input logic bridge_first
    );
        seq_pkg::mux_sel_t m;
        m = seq_pkg::MUX_TEMP;
        unique case (ph)
            3'h0: m = bridge_first ? seq_pkg::MUX_BRIDGE : seq_pkg::MUX_TEMP;
            3'h1: m = seq_pkg::MUX_OFFSET;
            3'h2: m = bridge_first ? seq_pkg::MUX_TEMP : seq_pkg::MUX_BRIDGE;
            3'h3: m = seq_pkg::MUX_CMODE;
            3'h4: m = seq_pkg::MUX_SHORT_POS;
            3'h5: m = seq_pkg::MUX_SHORT_NEG;
            default: m = seq_pkg::MUX_TEMP;
        endcase
        return m;
    endfunction

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmd.start = 1'b0;
        nxt_st.result_valid = 1'b0;
        nxt_st.cycle_end = 1'b0;
        bridge_n = (cfg_i.bridge_count < seq_pkg::BRIDGE_CNT_MIN) ?
            seq_pkg::BRIDGE_CNT_MIN : cfg_i.bridge_count;
        // start routine skips check phases, normal cycle ends after them
        last_phase = st_ff.start_done ? 3'h5 : 3'h2;
        unique case (st_ff.state)
            seq_pkg::ST_IDLE: begin
                if (run_i) begin
                    nxt_st.state = seq_pkg::ST_CONV;
                    nxt_st.phase = 3'h0;
                    nxt_st.bridge_left = bridge_n;
                    nxt_st.bridge_tot = bridge_n;
                    nxt_st.order_first = cfg_i.order_bridge_first;
                    nxt_st.cmd.start = 1'b1;
                    nxt_st.cmd.mux = phase_mux(3'h0,
                        cfg_i.order_bridge_first);
                    nxt_st.cmd.resolution = cfg_i.resolution;
                    nxt_st.cmd.second_order = cfg_i.second_order;
                    nxt_st.cmd.range_shift = cfg_i.range_shift;
                    nxt_st.cmd.reference_select =
                        cfg_i.reference_select;
                    nxt_st.cmd.temp_source = cfg_i.temp_source;
                end
            end
            seq_pkg::ST_CONV: begin
                if (conv_done) begin
                    nxt_st.state = seq_pkg::ST_HAND;
                    nxt_st.result_valid = 1'b1;
                    // no band check on the raw count
                    if (st_ff.cmd.resolution[1]) begin
                        nxt_st.result = adc_count_i[15:2];
                    end else begin
                        nxt_st.result = adc_count_i[13:0];
                    end
                end
            end
            seq_pkg::ST_HAND: begin
                if (ctrl_ack_i) begin
                    nxt_st.state = seq_pkg::ST_CONV;
                    nxt_st.cmd.start = 1'b1;
                    if (!st_ff.start_done &&
                        st_ff.start_cnt < seq_pkg::START_CONVS) begin
                        nxt_st.start_cnt = st_ff.start_cnt + 3'h1;
                    end
                    if (st_ff.cmd.mux == seq_pkg::MUX_BRIDGE &&
                        st_ff.bridge_left > 5'h01) begin
                        nxt_st.bridge_left = st_ff.bridge_left - 5'h01;
                    end else if (st_ff.phase >= last_phase &&
                        (st_ff.start_done ||
                         st_ff.start_cnt + 3'h1 >= seq_pkg::START_CONVS)) begin
                        nxt_st.phase = 3'h0;
                        nxt_st.start_done = 1'b1;
                        nxt_st.cycle_end = st_ff.start_done;
                        nxt_st.bridge_left = bridge_n;
                        nxt_st.bridge_tot = bridge_n;
                        nxt_st.order_first = cfg_i.order_bridge_first;
                        nxt_st.cmd.mux = phase_mux(3'h0,
                            cfg_i.order_bridge_first);
                        nxt_st.cmd.resolution = cfg_i.resolution;
                        nxt_st.cmd.second_order = cfg_i.second_order;
                        nxt_st.cmd.range_shift = cfg_i.range_shift;
                        nxt_st.cmd.reference_select = cfg_i.reference_select;
                        nxt_st.cmd.temp_source = cfg_i.temp_source;
                        if (!run_i) begin
                            nxt_st.state = seq_pkg::ST_IDLE;
                            nxt_st.cmd = st_ff.cmd;
                            nxt_st.cmd.start = 1'b0;
                        end
                    end else if (st_ff.phase >= last_phase) begin
                        nxt_st.phase = 3'h0;
                        nxt_st.bridge_left = st_ff.bridge_tot;
                        nxt_st.cmd.mux = phase_mux(3'h0,
                            st_ff.order_first);
                    end else begin
                        nxt_st.phase = st_ff.phase + 3'h1;
                        nxt_st.cmd.mux = phase_mux(st_ff.phase + 3'h1,
                            st_ff.order_first);
                    end
                end
            end
            default: nxt_st.state = seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.bridge_left <= seq_pkg::BRIDGE_CNT_RST;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign cmd_o = st_ff.cmd;
    assign result_o = st_ff.result;
    assign result_valid_o = st_ff.result_valid;
    assign start_done_o = st_ff.start_done;
    assign cycle_end_o = st_ff.cycle_end;
endmodule

// ==== verification/seq_chk.sv ====
// ----------------------------------------------------------------
// port checker for the measurement sequencer
// ----------------------------------------------------------------
module seq_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire seq_pkg::app_config_t cfg_i,
    input wire logic [15:0] adc_count_i,
    input wire logic ctrl_ack_i,
    input wire seq_pkg::conv_cmd_t cmd_o,
    input wire logic [13:0] result_o,
    input wire logic result_valid_o,
    input wire logic start_done_o,
    input wire logic cycle_end_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic busy_ff;
    int cnt_ff;
    int lim_ff;
    int res_w;
    assign res_w = 13 + int'(cmd_o.resolution);
    // cycles since the last conversion start
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            cnt_ff <= 0;
            lim_ff <= 0;
        end else if (cmd_o.start) begin
            busy_ff <= 1'b1;
            cnt_ff <= 1;
            lim_ff <= cmd_o.second_order ? 2 << ((res_w + 3) >> 1)
                                         : 2 << res_w;
        end else begin
            busy_ff <= busy_ff && !result_valid_o;
            cnt_ff <= cnt_ff + 1;
        end
    end
    conv_time_a: assert property (
        result_valid_o |-> busy_ff && cnt_ff >= lim_ff - 2
            && cnt_ff <= lim_ff + 4)
        else $error("conversion length off");
    one_conv_a: assert property (
        cmd_o.start |-> !busy_ff)
        else $error("start while conversion open");
    mux_step_a: assert property (
        $changed(cmd_o.mux) |-> cmd_o.start)
        else $error("mux moved without start");
    start_gap_a: assert property (
        cmd_o.start |=> !cmd_o.start [*8])
        else $error("starts too close");
    seg_a: assert property (
        result_valid_o && cmd_o.resolution[1]
            |-> result_o == adc_count_i[15:2])
        else $error("segment result wrong");
    direct_a: assert property (
        result_valid_o && !cmd_o.resolution[1]
            |-> result_o == adc_count_i[13:0])
        else $error("direct result wrong");
    start_phase_a: assert property (
        !start_done_o && cmd_o.start |-> cmd_o.mux inside
            {seq_pkg::MUX_TEMP, seq_pkg::MUX_OFFSET, seq_pkg::MUX_BRIDGE})
        else $error("check phase in start routine");
    done_hold_a: assert property (
        start_done_o |=> start_done_o)
        else $error("start done dropped");
    cycle_checks_a: assert property (
        cycle_end_o |-> $past(cmd_o.mux) == seq_pkg::MUX_SHORT_NEG)
        else $error("cycle ended without checks");
    ref_copy_a: assert property (
        $changed(cmd_o.reference_select) |-> cmd_o.start)
        else $error("reference moved mid conversion");
endmodule
bind bridge_measurement_sequencer seq_chk seq_chk_i (.sys_clk_i, .rst_i,
    .ce_i, .run_i, .cfg_i, .adc_count_i, .ctrl_ack_i, .cmd_o, .result_o,
    .result_valid_o, .start_done_o, .cycle_end_o);

// ==== verification/afe_model.sv ====
// ----------------------------------------------------------------
// front end model: new count per conversion
// ----------------------------------------------------------------
module afe_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire seq_pkg::conv_cmd_t cmd_i,
    output logic [15:0] adc_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] seq_ff;
    // counts may leave the 10..90 band; nothing flags them
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_ff <= 9'h000;
            adc_count_o <= 16'hffff;
        end else if (cmd_i.start) begin
            seq_ff <= seq_ff + 9'h001;
            adc_count_o <= {seq_ff[3:0] ^ 4'ha, cmd_i.mux, seq_ff ^ 9'h0c5};
        end
    end
endmodule

// ==== verification/bridge_measurement_sequencer_bench.sv ====
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
    n_mismatch++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module bridge_measurement_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam seq_pkg::app_config_t cfg_a = '{1'b0, 5'h02, 2'h2, 1'b1,
        2'h2, 1'b1, 2'h3};
    localparam seq_pkg::app_config_t cfg_b = '{1'b1, 5'h00, 2'h3, 1'b1,
        2'h1, 1'b0, 2'h1};
    localparam seq_pkg::app_config_t cfg_c = '{1'b0, 5'h1f, 2'h1, 1'b1,
        2'h0, 1'b1, 2'h2};
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic run_i = 1'b0;
    logic ctrl_ack_i = 1'b0;
    seq_pkg::app_config_t cfg_i = cfg_a;
    logic [15:0] adc_count_i;
    seq_pkg::conv_cmd_t cmd_o;
    seq_pkg::conv_cmd_t seen;
    logic [13:0] result_o;
    logic result_valid_o;
    logic start_done_o;
    logic cycle_end_o;
    logic sd_seen;
    logic [13:0] exp_r;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_end = 0;
    int k = 0;
    int ns = 0;
    seq_pkg::mux_sel_t mq[$];
    seq_pkg::app_config_t cq[$];
    seq_pkg::mux_sel_t spat[4] = '{seq_pkg::MUX_TEMP, seq_pkg::MUX_OFFSET,
        seq_pkg::MUX_BRIDGE, seq_pkg::MUX_BRIDGE};
    bridge_measurement_sequencer bridge_measurement_sequencer_i (
        .sys_clk_i, .rst_i, .ce_i(1'b1), .run_i, .cfg_i, .adc_count_i,
        .ctrl_ack_i, .cmd_o, .result_o, .result_valid_o, .start_done_o,
        .cycle_end_o);
    afe_model afe_model_i (.sys_clk_i, .rst_i, .cmd_i(cmd_o),
        .adc_count_o(adc_count_i));
    // ----------------------------------------------------------------
    // clock, cycle end monitor
    // ----------------------------------------------------------------
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (cycle_end_o === 1'b1 && start_done_o === 1'b1) n_end++;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task add_cycle(input seq_pkg::app_config_t c, input int nb);
        repeat (c.order_bridge_first ? nb : 1)
            mq.push_back(c.order_bridge_first ? seq_pkg::MUX_BRIDGE
                                              : seq_pkg::MUX_TEMP);
        mq.push_back(seq_pkg::MUX_OFFSET);
        repeat (c.order_bridge_first ? 1 : nb)
            mq.push_back(c.order_bridge_first ? seq_pkg::MUX_TEMP
                                              : seq_pkg::MUX_BRIDGE);
        mq.push_back(seq_pkg::MUX_CMODE);
        mq.push_back(seq_pkg::MUX_SHORT_POS);
        mq.push_back(seq_pkg::MUX_SHORT_NEG);
        while (cq.size() < mq.size()) cq.push_back(c);
    endtask
    // one conversion: stray ack mid conversion, then handover ack
    task conv;
        int i;
        i = 0;
        do begin
            @(posedge sys_clk_i);
            ctrl_ack_i <= 1'b0;
            i++;
        end while (cmd_o.start !== 1'b1 && i < 3000);
        seen = cmd_o;
        sd_seen = start_done_o;
        ctrl_ack_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            ctrl_ack_i <= 1'b0;
            i++;
        end while (result_valid_o !== 1'b1 && i < 6000);
        if (i >= 6000) begin
            n_mismatch++;
            stop_test();
        end
        exp_r = seen.resolution[1] ? adc_count_i[15:2] : adc_count_i[13:0];
        `CHK("result", exp_r, result_o)
        ctrl_ack_i <= 1'b1;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        add_cycle(cfg_a, 2);
        add_cycle(cfg_b, 1);
        add_cycle(cfg_c, 31);
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        run_i <= 1'b1;
        while (k < mq.size() && ns < 20) begin
            conv();
            if (sd_seen !== 1'b1) begin
                `CHK("start mux", spat[ns % 4], seen.mux)
                ns++;
            end else begin
                if (k == 0) `CHK("start length", 1'b1, ns >= 5)
                `CHK("mux", mq[k], seen.mux)
                `CHK("config", cq[k][7:0], seen[7:0])
                k++;
            end
            if (k == 1) cfg_i <= cfg_b;
            if (k == 8) cfg_i <= cfg_c;
        end
        repeat (4) @(posedge sys_clk_i);
        ctrl_ack_i <= 1'b0;
        run_i <= 1'b0;
        `CHK("cycle ends", 3, n_end)
        stop_test();
    end
endmodule
